// [hdl/fpga_config_loader.sv]
// Configuration loader: active serial flash master, passive slave and JTAG loading into config_ram.
// Assumes clk is the internal oscillator and every pin input is asynchronous to it.
`timescale 1ns/1ps
`include "fpga_config_loader_regs.svh"
module fpga_config_loader #(
  parameter int BITSTREAM_WORDS = 256,
  parameter int SPI_HALF        = 2,
  parameter int BUF_DEPTH       = 2,
  parameter int ADDR_W          = $clog2(BITSTREAM_WORDS)
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Configuration control pins
  input  wire logic              configResetN,
  input  wire logic [1:0]        modeSel,
  input  wire logic [2:0]        widthSel,
  // Active serial flash link
  output logic                   spiClk_q,
  output logic                   spiCsN_q,
  input  wire logic [3:0]        spiIoIn,
  output logic      [3:0]        spiIoOut_q,
  output logic      [3:0]        spiIoOe_q,
  // Passive slave link
  input  wire logic              pasClk,
  input  wire logic              pasCsN,
  input  wire logic [31:0]       pasData,
  // JTAG load path
  input  wire logic              jtagTck,
  input  wire logic              jtagTdi,
  input  wire logic              jtagShift,
  // Status
  output logic                   userMode_q,
  output logic                   overrun_q,
  // Readback of the configuration memory
  input  wire logic              cramRdEn,
  input  wire logic [ADDR_W-1:0] cramRdAddr,
  output logic      [31:0]       cramRdData_q
);

  localparam int DIV_W = 8;
  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int CNT_W = ADDR_W + 1;
  localparam logic [CNT_W-1:0] WORDS = CNT_W'(BITSTREAM_WORDS);
  localparam logic [15:0] GAP_CYC = 16'(`CFG_WAKE_GAP_CYC);
  localparam logic [7:0]  WAKE_OP = `CFG_OP_WAKE;

  // Bits per shift for a width code; unknown codes fall back to x1
  function automatic logic [5:0] widthBits(input logic [2:0] code);
    unique case (code)
      `CFG_WID_X2:  widthBits = 6'h02;
      `CFG_WID_X4:  widthBits = 6'h04;
      `CFG_WID_X8:  widthBits = 6'h08;
      `CFG_WID_X16: widthBits = 6'h10;
      `CFG_WID_X32: widthBits = 6'h20;
      default:      widthBits = 6'h01;
    endcase
  endfunction

  fpga_config_loader_pkg::pinIn_t     sync1_q, sync2_q, prev_q, pinsIn;
  fpga_config_loader_pkg::loadState_t state_q;
  fpga_config_loader_pkg::shiftReq_t  shReq;

  logic [1:0]           mode_q;
  logic [2:0]           width_q;
  logic [DIV_W-1:0]     divCnt_q;
  logic [6:0]           bitCnt_q;
  logic [15:0]          gapCnt_q;
  logic [`CFG_TX_W-1:0] txShift_q;
  logic [31:0]          asmWord_q;
  logic [5:0]           asmCnt_q;
  logic                 wordFull_q;
  logic [CNT_W-1:0]     pushCnt_q, wrCnt_q;
  logic [31:0]          fifoMem_q [BUF_DEPTH];
  logic [PTR_W-1:0]     wrPtr_q, rdPtr_q;
  logic [PTR_W:0]       fifoCnt_q;

  // Pins enter through two flip-flops; only the second stage and later are read
  assign pinsIn = '{configResetN, pasClk, pasCsN, pasData, jtagTck, jtagTdi, jtagShift, spiIoIn, modeSel, widthSel};
  always_ff @(posedge clk) begin
    if (ce) begin
      sync1_q <= pinsIn;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Edge detection and mode decode
  wire  cfgRelease  = sync2_q.configResetN & ~prev_q.configResetN;
  wire  cfgHeld     = ~sync2_q.configResetN;
  wire  pasRise     = sync2_q.pasClk & ~prev_q.pasClk;
  wire  tckRise     = sync2_q.jtagTck & ~prev_q.jtagTck;
  wire  pinActive   = sync2_q.modeSel == `CFG_MODE_ACTIVE;
  wire  [2:0] actW  = (width_q == `CFG_WID_X2 || width_q == `CFG_WID_X4) ? width_q : `CFG_WID_X1;
  wire  [2:0] effW  = (mode_q == `CFG_MODE_ACTIVE) ? actW :
                      (mode_q == `CFG_MODE_JTAG) ? `CFG_WID_X1 : width_q;
  wire  [7:0] readOp = (actW == `CFG_WID_X4) ? `CFG_OP_READ_X4 :
                       (actW == `CFG_WID_X2) ? `CFG_OP_READ_X2 : `CFG_OP_READ_X1;
  wire  allPushed   = pushCnt_q == WORDS;
  wire  allWritten  = wrCnt_q == WORDS;

  // Buffer handshake; the memory read port takes priority over writes
  wire  bufInReady  = fifoCnt_q != (PTR_W+1)'(BUF_DEPTH);
  wire  bufOutValid = fifoCnt_q != '0;
  wire  bufOutReady = ~cramRdEn;
  wire  bufPush     = wordFull_q & bufInReady;
  wire  bufPop      = bufOutValid & bufOutReady;
  wire  shiftAccept = ~wordFull_q | bufInReady;

  // Serial clock divided from the oscillator, stalled while the buffer and the pending word are both full
  wire  spiRun  = (state_q == fpga_config_loader_pkg::ST_WAKE) || (state_q == fpga_config_loader_pkg::ST_CMD) ||
                  (state_q == fpga_config_loader_pkg::ST_DATA);
  wire  tick    = spiRun & shiftAccept & (divCnt_q == DIV_W'(SPI_HALF - 1));
  wire  spiRise = tick & ~spiClk_q;
  wire  spiFall = tick & spiClk_q;
  wire  [6:0] bitNext = bitCnt_q + 7'h01;

  // Sample arrangement per active width; io1 carries the most significant bit on x2
  wire  [31:0] actSample = (actW == `CFG_WID_X4) ? {28'h0, sync2_q.spiIn} :
                           (actW == `CFG_WID_X2) ? {30'h0, sync2_q.spiIn[1:0]} : {31'h0, sync2_q.spiIn[1]};

  // Source of assembler requests per state
  wire  pasShift = (mode_q != `CFG_MODE_JTAG) & pasRise & ~sync2_q.pasCsN;
  wire  jtgShift = (mode_q == `CFG_MODE_JTAG) & tckRise & sync2_q.jtagShift;
  wire  datRise  = (state_q == fpga_config_loader_pkg::ST_DATA) & spiFall;  // Sync lag: needs SPI_HALF >= 2
  wire  psvOn    = state_q == fpga_config_loader_pkg::ST_PASSIVE;
  assign shReq.en    = datRise | (psvOn & (pasShift | jtgShift));
  assign shReq.nbits = widthBits(effW);
  assign shReq.data  = datRise ? actSample :
                       (mode_q == `CFG_MODE_JTAG) ? {31'h0, sync2_q.jtagTdi} : sync2_q.pasData;

  // Word assembly, most significant bits first
  wire  [31:0] shMask  = (shReq.nbits == `CFG_WORD_BITS) ? 32'hFFFF_FFFF : ((32'h0000_0001 << shReq.nbits) - 32'h0000_0001);
  wire  [31:0] asmNext = (asmWord_q << shReq.nbits) | (shReq.data & shMask);
  wire  [5:0]  cntNext = asmCnt_q + shReq.nbits;
  wire         doShift = shReq.en & shiftAccept & ~allPushed;
  wire         clrAsm  = cfgHeld | (state_q == fpga_config_loader_pkg::ST_IDLE) |
                         (state_q == fpga_config_loader_pkg::ST_DONE);

  // Assembler and pending word; a passive word arriving while full is dropped and flagged
  always_ff @(posedge clk) begin
    if (rst || (ce && clrAsm)) begin
      asmWord_q  <= 32'h0000_0000;
      asmCnt_q   <= 6'h00;
      wordFull_q <= 1'b0;
      pushCnt_q  <= '0;
    end else if (ce) begin
      if (bufPush) begin
        wordFull_q <= 1'b0;
        pushCnt_q  <= pushCnt_q + CNT_W'(1);
      end
      if (doShift) begin
        asmWord_q <= asmNext;
        asmCnt_q  <= (cntNext == `CFG_WORD_BITS) ? 6'h00 : cntNext;
        if (cntNext == `CFG_WORD_BITS) begin
          wordFull_q <= 1'b1;
        end
      end
    end
  end

  // Overrun flag, sticky until the next load is released
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (ce) begin
      overrun_q <= (shReq.en & ~shiftAccept & ~allPushed) | (overrun_q & ~cfgRelease);
    end
  end

  // Two-entry buffer between the assembler and the memory writer
  always_ff @(posedge clk) begin
    if (rst || (ce && clrAsm && !bufOutValid)) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      fifoCnt_q <= '0;
    end else if (ce) begin
      if (bufPush) begin
        fifoMem_q[wrPtr_q] <= asmWord_q;
        wrPtr_q            <= (wrPtr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : wrPtr_q + PTR_W'(1);
      end
      if (bufPop) begin
        rdPtr_q <= (rdPtr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : rdPtr_q + PTR_W'(1);
      end
      fifoCnt_q <= fifoCnt_q + (PTR_W+1)'(bufPush) - (PTR_W+1)'(bufPop);
    end
  end

  // Memory write address counts words written in this load
  always_ff @(posedge clk) begin
    if (rst || (ce && cfgRelease)) begin
      wrCnt_q <= '0;
    end else if (ce && bufPop) begin
      wrCnt_q <= wrCnt_q + CNT_W'(1);
    end
  end

  config_ram #(
    .ADDR_W (ADDR_W),
    .DATA_W (32)
  ) u_config_ram (
    .clk      (clk),
    .ce       (ce),
    .wrEn     (bufPop),
    .wrAddr   (wrCnt_q[ADDR_W-1:0]),
    .wrData   (fifoMem_q[rdPtr_q]),
    .rdEn     (cramRdEn),
    .rdAddr   (cramRdAddr),
    .rdData_q (cramRdData_q)
  );

  // Divider phase counter
  always_ff @(posedge clk) begin
    if (rst || (ce && (!spiRun || tick))) begin
      divCnt_q <= '0;
    end else if (ce && shiftAccept) begin
      divCnt_q <= divCnt_q + DIV_W'(1);
    end
  end

  // Load sequencer; a held configuration reset pin returns the sequencer, its flash link outputs and user mode to idle
  always_ff @(posedge clk) begin
    if (rst || (ce && cfgHeld)) begin
      state_q    <= fpga_config_loader_pkg::ST_IDLE;
      mode_q     <= `CFG_MODE_ACTIVE;
      width_q    <= `CFG_WID_X1;
      spiClk_q   <= 1'b0;
      spiCsN_q   <= 1'b1;
      spiIoOut_q <= 4'h0;
      spiIoOe_q  <= 4'h0;
      bitCnt_q   <= 7'h00;
      gapCnt_q   <= 16'h0000;
      txShift_q  <= '0;
      userMode_q <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        spiClk_q <= ~spiClk_q;
      end
      if (spiRise) begin
        bitCnt_q <= bitNext;
      end
      if (spiFall) begin
        spiIoOut_q[0] <= txShift_q[`CFG_TX_W-1];
        txShift_q     <= txShift_q << 1;
      end
      unique case (state_q)
        fpga_config_loader_pkg::ST_IDLE: begin
          if (cfgRelease) begin
            mode_q  <= sync2_q.modeSel;
            width_q <= sync2_q.widthSel;
            if (pinActive) begin
              state_q       <= fpga_config_loader_pkg::ST_WAKE;
              spiCsN_q      <= 1'b0;
              spiIoOe_q     <= 4'h1;
              spiIoOut_q[0] <= WAKE_OP[7];
              txShift_q     <= {WAKE_OP[6:0], 33'h0_0000_0000};
              bitCnt_q      <= 7'h00;
            end else begin
              state_q <= fpga_config_loader_pkg::ST_PASSIVE;
            end
          end
        end
        fpga_config_loader_pkg::ST_WAKE: begin
          if (spiFall && bitCnt_q == `CFG_OP_BITS) begin
            state_q  <= fpga_config_loader_pkg::ST_GAP;
            spiCsN_q <= 1'b1;
            gapCnt_q <= 16'h0000;
          end
        end
        fpga_config_loader_pkg::ST_GAP: begin
          gapCnt_q <= gapCnt_q + 16'h0001;
          if (gapCnt_q == GAP_CYC - 16'h0001) begin
            state_q       <= fpga_config_loader_pkg::ST_CMD;
            spiCsN_q      <= 1'b0;
            bitCnt_q      <= 7'h00;
            spiIoOut_q[0] <= readOp[7];
            txShift_q     <= {readOp[6:0], `CFG_START_ADDR, `CFG_DUMMY_BYTE, 1'b0};
          end
        end
        fpga_config_loader_pkg::ST_CMD: begin
          if (spiFall && bitCnt_q == `CFG_HDR_BITS && actW != `CFG_WID_X1) begin
            spiIoOe_q <= 4'h0;  // Free the lines before the flash turns them round
          end
          if (spiFall && bitCnt_q == `CFG_HDR_DUMMY) begin
            state_q <= fpga_config_loader_pkg::ST_DATA;
          end
        end
        fpga_config_loader_pkg::ST_DATA: begin
          if (allPushed) begin
            state_q   <= fpga_config_loader_pkg::ST_DONE;
            spiCsN_q  <= 1'b1;
            spiClk_q  <= 1'b0;
            spiIoOe_q <= 4'h0;
          end
        end
        fpga_config_loader_pkg::ST_PASSIVE: begin
          if (allPushed) begin
            state_q <= fpga_config_loader_pkg::ST_DONE;
          end
        end
        fpga_config_loader_pkg::ST_DONE: begin
          userMode_q <= allWritten;
        end
        default: begin
          state_q <= fpga_config_loader_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [hdl/fpga_config_loader_regs.svh]
// Constants of the configuration loader: opcodes, mode codes, timing and field sizes.
// Assumes the core clock is the internal oscillator; included by the loader and its package users.
// Function
// - The device loads its volatile configuration memory after power-up and stays out of user mode until done.
// - One control block runs the whole load and writes the configuration memory from the bitstream.
// - In active mode the device itself sequences the load as master of the serial link.
// - In active mode the serial clock is derived from the device's own oscillator.
// - In active mode the control block drives command and address toward the external flash.
// - The first command sent to the flash is the release-from-deep-power-down instruction.
// - After the wake-up command the sequencer waits at least 30 us before the fast read.
// - The fast read starts at the 24-bit flash address zero and reads sequentially.
// - The device also accepts its configuration through the JTAG path as a separate mode.
// - Widths are x1/x2/x4 in active mode, x1 to x32 in passive mode and x1 in JTAG mode.
// - The outside holds the configuration reset pin low, and loading starts on its rising edge.
`ifndef FPGA_CONFIG_LOADER_REGS_SVH
`define FPGA_CONFIG_LOADER_REGS_SVH

`define CFG_CLK_PERIOD_NS 25
`define CFG_WAKE_GAP_US   30
`define CFG_WAKE_GAP_CYC  ((`CFG_WAKE_GAP_US * 1000 + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

`define CFG_OP_WAKE       8'hAB
`define CFG_OP_READ_X1    8'h0B
`define CFG_OP_READ_X2    8'h3B
`define CFG_OP_READ_X4    8'h6B
`define CFG_START_ADDR    24'h00_0000
`define CFG_DUMMY_BYTE    8'h00
`define CFG_OP_BITS       7'h08
`define CFG_HDR_BITS      7'h20
`define CFG_HDR_DUMMY     7'h28
`define CFG_TX_W          40
`define CFG_WORD_BITS     6'h20

`define CFG_MODE_ACTIVE   2'h0
`define CFG_MODE_PASSIVE  2'h1
`define CFG_MODE_JTAG     2'h2

`define CFG_WID_X1        3'h0
`define CFG_WID_X2        3'h1
`define CFG_WID_X4        3'h2
`define CFG_WID_X8        3'h3
`define CFG_WID_X16       3'h4
`define CFG_WID_X32       3'h5

`endif

// [hdl/fpga_config_loader_pkg.sv]
// Types shared by the configuration loader.
// Assumes the constants header is included by the files that use these types.
package fpga_config_loader_pkg;

  // Load sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_WAKE    = 7'b000_0010,
    ST_GAP     = 7'b000_0100,
    ST_CMD     = 7'b000_1000,
    ST_DATA    = 7'b001_0000,
    ST_PASSIVE = 7'b010_0000,
    ST_DONE    = 7'b100_0000
  } loadState_t;

  // All asynchronous pin inputs, synchronised together
  typedef struct packed {
    logic        configResetN;
    logic        pasClk;
    logic        pasCsN;
    logic [31:0] pasData;
    logic        jtagTck;
    logic        jtagTdi;
    logic        jtagShift;
    logic [3:0]  spiIn;
    logic [1:0]  modeSel;
    logic [2:0]  widthSel;
  } pinIn_t;

  // One request to the word assembler
  typedef struct packed {
    logic        en;
    logic [5:0]  nbits;
    logic [31:0] data;
  } shiftReq_t;

endpackage

// [hdl/config_ram.sv]
// Configuration memory: one write port, one read port with registered read data.
// Assumes a single clock; write and read may happen in the same cycle.
`timescale 1ns/1ps
module config_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and enable
  input  wire logic              clk,
  input  wire logic              ce,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  // Read port
  input  wire logic              rdEn,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData_q
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // No reset on the array; read data is held until the next read
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      if (rdEn) begin
        rdData_q <= mem[rdAddr];
      end
    end
  end

endmodule

// [verif/fpga_config_loader_props.sv]
// Checker of the loader's serial flash pins and status flags.
// Assumes it is bound into fpga_config_loader and that ce stays high.
`timescale 1ns/1ps
`include "fpga_config_loader_regs.svh"
module fpga_config_loader_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Control pin
  input wire logic       configResetN,
  // Flash link
  input wire logic       spiClk_q,
  input wire logic       spiCsN_q,
  input wire logic [3:0] spiIoOut_q,
  input wire logic [3:0] spiIoOe_q,
  // Status
  input wire logic       userMode_q,
  input wire logic       overrun_q
);
  logic [6:0]  riseCnt;
  logic [31:0] mosiSh;
  logic [11:0] hiCnt;
  logic        clkPrev;
  logic        csPrev;
  logic        lastWake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Rises and master bits of the current frame; saturates so long reads cannot wrap
  always_ff @(posedge clk) begin
    clkPrev <= spiClk_q;
    csPrev  <= spiCsN_q;
    if (rst || spiCsN_q) begin
      riseCnt <= 7'h00;
    end else if (spiClk_q && !clkPrev && riseCnt != 7'h7f) begin
      riseCnt <= riseCnt + 7'h01;
      mosiSh  <= {mosiSh[30:0], spiIoOut_q[0]};
    end
  end

  // Deselected stretch length, and whether the frame just closed was the wake byte
  always_ff @(posedge clk) begin
    if (rst || !spiCsN_q) begin
      hiCnt <= 12'h000;
    end else if (hiCnt != 12'hfff) begin
      hiCnt <= hiCnt + 12'h001;
    end
    if (rst) begin
      lastWake <= 1'b0;
    end else if (spiCsN_q && !csPrev) begin
      lastWake <= (riseCnt == 7'h08);
    end
  end

  a_cs_clock_idle: assert property (spiCsN_q |-> !spiClk_q)
    else $error("serial clock moved while deselected");
  a_user_link_quiet: assert property (userMode_q |-> spiCsN_q && spiIoOe_q == 4'h0)
    else $error("user mode with the flash link still active");
  a_reset_values: assert property ($fell(rst) |-> spiCsN_q && spiIoOe_q == 4'h0 && !userMode_q && !overrun_q)
    else $error("outputs not idle after reset");
  a_wake_gap_len: assert property ($fell(spiCsN_q) && lastWake |->
    hiCnt >= `CFG_WAKE_GAP_CYC && hiCnt <= `CFG_WAKE_GAP_CYC + 8)
    else $error("gap after wake byte out of range");
  a_wake_byte_code: assert property (spiCsN_q && !csPrev && riseCnt == 7'h08 |-> mosiSh[7:0] == `CFG_OP_WAKE)
    else $error("eight-clock frame was not the wake byte");
  a_read_header: assert property ($rose(riseCnt == 7'h20) |->
    mosiSh inside {32'h0B00_0000, 32'h3B00_0000, 32'h6B00_0000})
    else $error("read header wrong opcode or address");
  a_header_drive: assert property (!spiCsN_q && riseCnt < 7'h20 |-> spiIoOe_q == 4'h1)
    else $error("header not driven on io0 alone");
  a_reset_pin_abort: assert property ($fell(configResetN) |-> ##[1:5] (!userMode_q && spiCsN_q))
    else $error("reset pin low did not stop the loader");
  a_overrun_sticky: assert property (overrun_q && configResetN && $past(configResetN, 6) |=> overrun_q)
    else $error("overrun flag dropped without a new load");

  // Main scenarios reached
  c_wake_done: cover property (spiCsN_q && !csPrev && riseCnt == 7'h08);
  c_user_on: cover property ($rose(userMode_q));
  c_overrun: cover property ($rose(overrun_q));
endmodule

bind fpga_config_loader fpga_config_loader_props i_fpga_config_loader_props (
  .clk(clk), .rst(rst), .configResetN(configResetN), .spiClk_q(spiClk_q), .spiCsN_q(spiCsN_q),
  .spiIoOut_q(spiIoOut_q), .spiIoOe_q(spiIoOe_q), .userMode_q(userMode_q), .overrun_q(overrun_q)
);

// [verif/flash_model.sv]
// Behavioural serial flash: records headers and answers fast reads with the bench's words.
// Assumes a mode-0 master; lines the flash does not drive show a toggling value.
`timescale 1ns/1ps
module flash_model (
  // Device side of the link
  input  wire logic        spiClk,
  input  wire logic        spiCsN,
  input  wire logic [3:0]  ioOut,
  input  wire logic [3:0]  ioOe,
  output logic      [3:0]  ioIn,
  // Bench side
  input  wire logic [2:0]  widthSel,
  input  wire logic [31:0] words [4]
);
  logic [3:0]  drv = 4'h0;
  logic [3:0]  en = 4'h0;
  logic [3:0]  junk = 4'h5;
  logic [31:0] hdr [2];
  logic [2:0]  w;
  int          rises = 0;
  int          pos = 0;
  int          frames = 0;
  int          wakeRises = 0;
  time         tRise = 0;
  time         gapNs = 0;

  // Wire level: device drive wins, then the flash, else a value that never settles
  assign ioIn = (ioOe & ioOut) | (~ioOe & ((en & drv) | (~en & junk)));
  assign w = (widthSel == 3'h1) ? 3'h2 : ((widthSel == 3'h2) ? 3'h4 : 3'h1);

  function automatic logic bit_at(input int i);
    return words[(i / 32) % 4][31 - i % 32];
  endfunction

  task automatic clear_frames();
    frames = 0;
  endtask

  // A new frame restarts header capture and data position
  always @(negedge spiCsN) begin
    rises = 0;
    pos = 0;
    if (frames < 2) hdr[frames] = 32'h0000_0000;
    if (frames == 1) gapNs = $time - tRise;
  end

  // Frame end releases the data lines
  always @(posedge spiCsN) begin
    en = 4'h0;
    tRise = $time;
    if (frames == 0) wakeRises = rises;
    frames = frames + 1;
  end

  // Header bits are taken from io0 on rises
  always @(posedge spiClk) begin
    if (!spiCsN) begin
      if (rises < 32 && frames < 2) hdr[frames] = {hdr[frames][30:0], ioIn[0]};
      rises = rises + 1;
    end
  end

  // Stored words go out on falls once the dummy clocks are past
  always @(negedge spiClk) begin
    junk = ~junk;
    if (!spiCsN && rises >= 40) begin
      en = (w == 3'h1) ? 4'h2 : ((w == 3'h2) ? 4'h3 : 4'hf);
      for (int j = 0; j < w; j++) drv[(w == 3'h1) ? 1 : (w - 1 - j)] = bit_at(pos + j);
      pos = pos + w;
    end
  end
endmodule

// [verif/fpga_config_loader_tb_top.sv]
// Self-checking bench of the configuration loader with a behavioural serial flash.
// Assumes the loader holds four words; every pin is driven on the falling clock edge.
`timescale 1ns/1ps
`include "fpga_config_loader_regs.svh"
module fpga_config_loader_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        configResetN = 1'b0;
  logic [1:0]  modeSel = 2'h0;
  logic [2:0]  widthSel = 3'h0;
  logic        spiClk_q, spiCsN_q, userMode_q, overrun_q;
  logic [3:0]  spiIoIn, spiIoOut_q, spiIoOe_q;
  logic        pasClk = 1'b0, pasCsN = 1'b1, jtagTck = 1'b0, jtagTdi = 1'b0, jtagShift = 1'b0;
  logic [31:0] pasData = 32'h0000_0000;
  logic        cramRdEn = 1'b0;
  logic [1:0]  cramRdAddr = 2'h0;
  logic [31:0] cramRdData_q;
  logic [31:0] words [4] = '{32'hC3A5_0F1E, 32'h8000_0001, 32'h5A69_96E1, 32'h0123_FEDC};
  int          fail_count = 0;
  int          checks_done = 0;

  always #12.5 clk = ~clk;

  // Small bitstream keeps each load short
  fpga_config_loader #(.BITSTREAM_WORDS(4)) i_fpga_config_loader (
    .clk(clk), .rst(rst), .ce(1'b1), .configResetN(configResetN), .modeSel(modeSel), .widthSel(widthSel),
    .spiClk_q(spiClk_q), .spiCsN_q(spiCsN_q), .spiIoIn(spiIoIn), .spiIoOut_q(spiIoOut_q), .spiIoOe_q(spiIoOe_q),
    .pasClk(pasClk), .pasCsN(pasCsN), .pasData(pasData), .jtagTck(jtagTck), .jtagTdi(jtagTdi),
    .jtagShift(jtagShift), .userMode_q(userMode_q), .overrun_q(overrun_q), .cramRdEn(cramRdEn),
    .cramRdAddr(cramRdAddr), .cramRdData_q(cramRdData_q));
  flash_model i_flash_model (.spiClk(spiClk_q), .spiCsN(spiCsN_q), .ioOut(spiIoOut_q), .ioOe(spiIoOe_q),
    .ioIn(spiIoIn), .widthSel(widthSel), .words(words));

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  // Pins settle well before release so the mode and width are taken cleanly
  task automatic start_load(input logic [1:0] mode, input logic [2:0] wid);
    configResetN = 1'b0;
    modeSel = mode;
    widthSel = wid;
    repeat (20) @(negedge clk);
    check(spiCsN_q === 1'b1 && userMode_q === 1'b0, "link busy while reset pin low");
    i_flash_model.clear_frames();
    configResetN = 1'b1;
    repeat (6) @(negedge clk);
    check(overrun_q === 1'b0 && userMode_q === 1'b0, "status not cleared by release");
  endtask

  // Bounded wait; a miss ends the run
  task automatic wait_user(input int limit);
    int n;
    n = 0;
    while (userMode_q !== 1'b1 && n < limit) begin
      @(negedge clk);
      n++;
    end
    check(userMode_q, "load did not complete");
    if (userMode_q !== 1'b1) give_verdict();
  endtask

  task automatic check_ram(input int count);
    for (int k = 0; k < count; k++) begin
      cramRdEn = 1'b1;
      cramRdAddr = k[1:0];
      @(negedge clk);
      cramRdEn = 1'b0;
      check(cramRdData_q === words[k], "config memory word differs");
      @(negedge clk);
    end
  endtask

  // Outside master: 200 ns link clock, data MSB first, unused data lines held at ones
  task automatic shift_in(input logic viaJtag, input int w, input int edges);
    logic [31:0] chunk;
    for (int e = 0; e < edges; e++) begin
      chunk = 32'h0000_0000;
      for (int j = 0; j < w; j++) chunk = {chunk[30:0], words[((e * w + j) / 32) % 4][31 - (e * w + j) % 32]};
      pasCsN = viaJtag;
      jtagShift = !viaJtag ? 1'b0 : 1'b1;
      pasData = (w == 32) ? chunk : ((32'hFFFF_FFFF << w) | chunk);
      jtagTdi = chunk[0];
      repeat (4) @(negedge clk);
      if (viaJtag) jtagTck = 1'b1;
      else pasClk = 1'b1;
      repeat (4) @(negedge clk);
      jtagTck = 1'b0;
      pasClk = 1'b0;
    end
    pasCsN = 1'b1;
    jtagShift = 1'b0;
  endtask

  // Reset pin pulled in mid read: loader must drop the link at once
  task automatic run_abort();
    int n;
    start_load(2'h0, 3'h0);
    n = 0;
    while (i_flash_model.rises < 60 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check(n < 4000, "read frame never reached data");
    configResetN = 1'b0;
    repeat (6) @(negedge clk);
    check(spiCsN_q === 1'b1 && spiClk_q === 1'b0 && userMode_q === 1'b0, "load not stopped");
    if (n >= 4000) give_verdict();
  endtask

  // Active loads at each serial width
  task automatic run_active();
    logic [7:0] op [3];
    op = '{`CFG_OP_READ_X1, `CFG_OP_READ_X2, `CFG_OP_READ_X4};
    for (int w = 0; w < 3; w++) begin
      start_load(2'h0, w[2:0]);
      wait_user(6000);
      check(i_flash_model.hdr[0][7:0] === `CFG_OP_WAKE && i_flash_model.wakeRises == 8, "wake byte");
      check(i_flash_model.gapNs >= 30000, "gap before read too short");
      check(i_flash_model.hdr[1] === {op[w], `CFG_START_ADDR}, "read header");
      check(i_flash_model.frames == 2 && spiCsN_q === 1'b1, "frames or select after load");
      check_ram(4);
    end
  endtask

  // Passive loads at every width; the device must leave the flash link alone
  task automatic run_passive();
    for (int w = 0; w < 6; w++) begin
      start_load((w == 5) ? 2'h3 : 2'h1, w[2:0]);
      shift_in(1'b0, 1 << w, 128 >> w);
      wait_user(200);
      check(spiCsN_q === 1'b1 && overrun_q === 1'b0, "passive load disturbed link or flag");
      check_ram(4);
    end
  endtask

  task automatic run_jtag();
    start_load(2'h2, 3'h5);
    shift_in(1'b1, 1, 128);
    wait_user(200);
    check_ram(4);
  endtask

  // Memory reads stall the buffer while whole words keep arriving
  task automatic run_overrun();
    start_load(2'h1, 3'h5);
    cramRdEn = 1'b1;
    shift_in(1'b0, 32, 6);
    check(overrun_q === 1'b1, "dropped words not flagged");
    cramRdEn = 1'b0;
    repeat (10) @(negedge clk);
    check(overrun_q === 1'b1, "overrun flag not held");
    check_ram(2);
    start_load(2'h1, 3'h5);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    run_abort();
    run_active();
    run_passive();
    run_jtag();
    run_overrun();
    give_verdict();
  end
endmodule
